// *** radio_cfg_pkg.sv ***
// Purpose: Shared constants for the serial configuration block
// Assumes: Serial header byte is {read, burst, address[5:0]}
// Notes: Address map, field positions, reset values and strobe codes
package radio_cfg_pkg;

  // ===========================================================
  // Header byte layout
  localparam int HDR_READ_BIT = 7;
  localparam int HDR_BURST_BIT = 6;

  // ===========================================================
  // Register addresses
  localparam logic [5:0] ADDR_PIN_TWO_CFG = 6'h00;
  localparam logic [5:0] ADDR_PIN_ONE_CFG = 6'h01;
  localparam logic [5:0] ADDR_PIN_ZERO_CFG = 6'h02;
  localparam logic [5:0] ADDR_TX_THRESHOLD_SELECT = 6'h03;
  localparam logic [5:0] ADDR_STROBE_FIRST = 6'h30;
  localparam logic [5:0] ADDR_STROBE_LAST = 6'h3D;
  localparam logic [5:0] ADDR_PART_NUMBER = 6'h30;
  localparam logic [5:0] ADDR_RADIO_STATE = 6'h35;
  localparam logic [5:0] ADDR_PACKET_STATUS = 6'h38;
  localparam logic [5:0] ADDR_TX_BYTE_COUNT = 6'h3A;
  localparam logic [5:0] ADDR_POWER_TABLE = 6'h3E;

  // ===========================================================
  // Command strobe addresses
  localparam logic [5:0] CMD_CHIP_RESET = 6'h30;
  localparam logic [5:0] CMD_SYNTH_ON = 6'h31;
  localparam logic [5:0] CMD_CRYSTAL_OFF = 6'h32;
  localparam logic [5:0] CMD_CALIBRATE = 6'h33;
  localparam logic [5:0] CMD_TRANSMIT = 6'h35;
  localparam logic [5:0] CMD_IDLE = 6'h36;
  localparam logic [5:0] CMD_POWER_DOWN = 6'h39;
  localparam logic [5:0] CMD_FLUSH_TX = 6'h3B;
  localparam logic [5:0] CMD_NO_OP = 6'h3D;

  // ===========================================================
  // Pin configuration fields
  localparam int PIN_DRIVE_BIT = 7;
  localparam int PIN_INVERT_BIT = 6;
  localparam int PIN_SELECT_MSB = 5;
  localparam logic [5:0] SELECT_THREE_STATE = 6'h2E;

  // ===========================================================
  // Reset values
  localparam logic [7:0] RST_PIN_TWO_CFG = 8'h29;
  localparam logic [7:0] RST_PIN_ONE_CFG = 8'h2E;
  localparam logic [7:0] RST_PIN_ZERO_CFG = 8'h3F;
  localparam logic [7:0] RST_TX_THRESHOLD_SELECT = 8'h07;
  localparam logic [7:0] RST_POWER_TABLE = 8'h00;

  // ===========================================================
  // Threshold mapping: bytes = base - step * setting
  localparam logic [6:0] THR_BASE_BYTES = 7'h3D;
  localparam int THR_STEP_SHIFT = 2;
  localparam int THR_FIELD_MSB = 3;

  // Power table depth
  localparam int POWER_TABLE_DEPTH = 8;

  // Part number value is arbitrary
  localparam logic [7:0] PART_NUMBER_VALUE = 8'h5A;

endpackage

// *** output_pin_mux.sv ***
// Purpose: Signal select and polarity for one general output pin
// Assumes: All selectable signals arrive on one 64-bit vector
// Notes: Purely combinational; the caller registers the outputs
`timescale 1ns/1ps
module output_pin_mux (
  input wire logic [63:0] signals_i,
  input wire logic [5:0] select_i,
  input wire logic invert_i,
  output logic level_o,
  output logic enable_o
);

  // Polarity applies to the selected signal only
  always_comb begin
    level_o = signals_i[select_i] ^ invert_i;
    enable_o = (select_i != radio_cfg_pkg::SELECT_THREE_STATE);
  end

endmodule

// *** radio_cfg_regs.sv ***
// Purpose: Serial register map, command strobes and output pin config
// Assumes: Serial pins are synchronous to mclk_i and much slower
// Notes: Data sampled on serial clock rise, shifted out on its fall
`timescale 1ns/1ps
module radio_cfg_regs (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic serial_clk_i,
  input wire logic serial_sel_low_i,
  input wire logic serial_data_i,
  output logic serial_data_o,
  input wire logic chip_ready_low_i,
  input wire logic [4:0] radio_state_i,
  input wire logic [7:0] packet_status_i,
  input wire logic [7:0] tx_byte_count_i,
  input wire logic [63:0] pin_signals_i,
  output logic general_output_two_o,
  output logic general_output_two_oe_o,
  output logic general_output_one_o,
  output logic general_output_one_oe_o,
  output logic general_output_zero_o,
  output logic general_output_zero_oe_o,
  output logic output_drive_strength_o,
  output logic tx_threshold_reached_o,
  output logic chip_reset_strobe_o,
  output logic synth_on_strobe_o,
  output logic crystal_off_strobe_o,
  output logic calibrate_strobe_o,
  output logic transmit_strobe_o,
  output logic idle_strobe_o,
  output logic power_down_strobe_o,
  output logic flush_tx_strobe_o,
  output logic no_op_strobe_o
);

  // ===========================================================
  // State
  typedef struct packed {
    logic sclk_d;
    logic sel_low_d;
    logic [2:0] bit_cnt;
    logic [7:0] in_shift;
    logic [7:0] out_shift;
    logic header_phase;
    logic is_read;
    logic is_burst;
    logic [5:0] addr;
    logic [2:0] table_idx;
    logic serial_out;
    logic [6:0] pin_two_cfg;
    logic [7:0] pin_one_cfg;
    logic [7:0] pin_zero_cfg;
    logic [7:0] threshold_select;
    logic [7:0][7:0] power_table;
    logic [8:0] strobes;
    logic [2:0] pin_level;
    logic [2:0] pin_enable;
    logic thr_reached;
  } state_t;

  state_t cur;
  state_t next_cur;

  logic sclk_rise;
  logic sclk_fall;
  logic sel_fall;
  logic [7:0] rx_byte;
  logic [6:0] thr_bytes;
  logic [2:0] mux_level;
  logic [2:0] mux_enable;
  logic [7:0] status_byte;

  // ===========================================================
  // Pin multiplexers; polarity after the select
  output_pin_mux pin_two_mux (
    .signals_i(pin_signals_i),
    .select_i(cur.pin_two_cfg[radio_cfg_pkg::PIN_SELECT_MSB:0]),
    .invert_i(cur.pin_two_cfg[radio_cfg_pkg::PIN_INVERT_BIT]),
    .level_o(mux_level[2]),
    .enable_o(mux_enable[2])
  );

  output_pin_mux pin_one_mux (
    .signals_i(pin_signals_i),
    .select_i(cur.pin_one_cfg[radio_cfg_pkg::PIN_SELECT_MSB:0]),
    .invert_i(cur.pin_one_cfg[radio_cfg_pkg::PIN_INVERT_BIT]),
    .level_o(mux_level[1]),
    .enable_o(mux_enable[1])
  );

  output_pin_mux pin_zero_mux (
    .signals_i(pin_signals_i),
    .select_i(cur.pin_zero_cfg[radio_cfg_pkg::PIN_SELECT_MSB:0]),
    .invert_i(cur.pin_zero_cfg[radio_cfg_pkg::PIN_INVERT_BIT]),
    .level_o(mux_level[0]),
    .enable_o(mux_enable[0])
  );

  // ===========================================================
  // Read data for one address
  function automatic logic [7:0] read_reg(input state_t s,
                                          input logic [5:0] a,
                                          input logic burst);
    logic [7:0] d;
    d = 8'h00;
    if (a == radio_cfg_pkg::ADDR_PIN_TWO_CFG) begin
      d = {1'b0, s.pin_two_cfg};
    end else if (a == radio_cfg_pkg::ADDR_PIN_ONE_CFG) begin
      d = s.pin_one_cfg;
    end else if (a == radio_cfg_pkg::ADDR_PIN_ZERO_CFG) begin
      d = s.pin_zero_cfg;
    end else if (a == radio_cfg_pkg::ADDR_TX_THRESHOLD_SELECT) begin
      d = s.threshold_select;
    end else if (a == radio_cfg_pkg::ADDR_POWER_TABLE) begin
      d = s.power_table[s.table_idx];
    end else if (!burst) begin
      d = 8'h00;
    end else if (a == radio_cfg_pkg::ADDR_PART_NUMBER) begin
      d = radio_cfg_pkg::PART_NUMBER_VALUE;
    end else if (a == radio_cfg_pkg::ADDR_RADIO_STATE) begin
      d = {3'h0, radio_state_i};
    end else if (a == radio_cfg_pkg::ADDR_PACKET_STATUS) begin
      d = packet_status_i;
    end else if (a == radio_cfg_pkg::ADDR_TX_BYTE_COUNT) begin
      d = tx_byte_count_i;
    end
    return d;
  endfunction

  // Strobe decode, one-hot in order of the strobe ports
  function automatic logic [8:0] strobe_decode(input logic [5:0] a);
    logic [8:0] v;
    v = 9'h000;
    case (a)
      radio_cfg_pkg::CMD_CHIP_RESET: v[0] = 1'b1;
      radio_cfg_pkg::CMD_SYNTH_ON: v[1] = 1'b1;
      radio_cfg_pkg::CMD_CRYSTAL_OFF: v[2] = 1'b1;
      radio_cfg_pkg::CMD_CALIBRATE: v[3] = 1'b1;
      radio_cfg_pkg::CMD_TRANSMIT: v[4] = 1'b1;
      radio_cfg_pkg::CMD_IDLE: v[5] = 1'b1;
      radio_cfg_pkg::CMD_POWER_DOWN: v[6] = 1'b1;
      radio_cfg_pkg::CMD_FLUSH_TX: v[7] = 1'b1;
      radio_cfg_pkg::CMD_NO_OP: v[8] = 1'b1;
      default: v = 9'h000;
    endcase
    return v;
  endfunction

  // ===========================================================
  // Edge detection and derived values
  always_comb begin
    sclk_rise = serial_clk_i & ~cur.sclk_d;
    sclk_fall = ~serial_clk_i & cur.sclk_d;
    sel_fall = ~serial_sel_low_i & cur.sel_low_d;
    rx_byte = {cur.in_shift[6:0], serial_data_i};
    thr_bytes = radio_cfg_pkg::THR_BASE_BYTES -
                7'({cur.threshold_select[radio_cfg_pkg::THR_FIELD_MSB:0],
                    2'b00});
    status_byte = {chip_ready_low_i, radio_state_i[2:0], 4'h0};
  end

  // ===========================================================
  // Next state
  always_comb begin
    next_cur = cur;
    next_cur.sclk_d = serial_clk_i;
    next_cur.sel_low_d = serial_sel_low_i;
    next_cur.strobes = 9'h000;
    next_cur.pin_level = mux_level;
    next_cur.pin_enable = mux_enable;
    next_cur.thr_reached = (tx_byte_count_i[6:0] >= thr_bytes);

    if (serial_sel_low_i) begin
      // Deselected: frame ends, power table index rewinds
      next_cur.bit_cnt = 3'h0;
      next_cur.header_phase = 1'b1;
      next_cur.table_idx = 3'h0;
    end else if (sel_fall) begin
      // Status byte goes out while the header comes in
      next_cur.bit_cnt = 3'h0;
      next_cur.header_phase = 1'b1;
      next_cur.out_shift = status_byte;
      next_cur.serial_out = status_byte[7];
    end else if (sclk_rise) begin
      next_cur.in_shift = rx_byte;
      next_cur.out_shift = {cur.out_shift[6:0], 1'b0};
      next_cur.bit_cnt = cur.bit_cnt + 3'h1;
      if (cur.bit_cnt == 3'h7) begin
        if (cur.header_phase) begin
          next_cur.is_read = rx_byte[radio_cfg_pkg::HDR_READ_BIT];
          next_cur.is_burst = rx_byte[radio_cfg_pkg::HDR_BURST_BIT];
          next_cur.addr = rx_byte[5:0];
          next_cur.out_shift = read_reg(cur, rx_byte[5:0],
                               rx_byte[radio_cfg_pkg::HDR_BURST_BIT]);
          if (rx_byte[5:0] >= radio_cfg_pkg::ADDR_STROBE_FIRST &&
              rx_byte[5:0] <= radio_cfg_pkg::ADDR_STROBE_LAST &&
              !rx_byte[radio_cfg_pkg::HDR_BURST_BIT]) begin
            next_cur.strobes = strobe_decode(rx_byte[5:0]);
            next_cur.out_shift = status_byte;
          end else begin
            next_cur.header_phase = 1'b0;
          end
        end else begin
          if (!cur.is_read) begin
            if (cur.addr == radio_cfg_pkg::ADDR_PIN_TWO_CFG) begin
              next_cur.pin_two_cfg = rx_byte[6:0];
            end else if (cur.addr == radio_cfg_pkg::ADDR_PIN_ONE_CFG) begin
              next_cur.pin_one_cfg = rx_byte;
            end else if (cur.addr == radio_cfg_pkg::ADDR_PIN_ZERO_CFG) begin
              next_cur.pin_zero_cfg = rx_byte;
            end else if (cur.addr == radio_cfg_pkg::ADDR_TX_THRESHOLD_SELECT) begin
              next_cur.threshold_select = rx_byte;
            end else if (cur.addr == radio_cfg_pkg::ADDR_POWER_TABLE) begin
              next_cur.power_table[cur.table_idx] = rx_byte;
            end
          end
          // Advance: table index or burst address
          if (cur.addr == radio_cfg_pkg::ADDR_POWER_TABLE) begin
            next_cur.table_idx = cur.table_idx + 3'h1;
          end else if (cur.is_burst &&
                       cur.addr < radio_cfg_pkg::ADDR_STROBE_FIRST) begin
            next_cur.addr = cur.addr + 6'h01;
          end
          if (!cur.is_burst) begin
            next_cur.header_phase = 1'b1;
            next_cur.out_shift = status_byte;
          end else begin
            next_cur.out_shift = read_reg(next_cur, next_cur.addr, 1'b1);
          end
        end
      end
    end else if (sclk_fall) begin
      next_cur.serial_out = cur.out_shift[7];
    end

    // Chip reset strobe restores the pin and threshold config defaults
    if (next_cur.strobes[0]) begin
      next_cur.pin_two_cfg = radio_cfg_pkg::RST_PIN_TWO_CFG[6:0];
      next_cur.pin_one_cfg = radio_cfg_pkg::RST_PIN_ONE_CFG;
      next_cur.pin_zero_cfg = radio_cfg_pkg::RST_PIN_ZERO_CFG;
      next_cur.threshold_select = radio_cfg_pkg::RST_TX_THRESHOLD_SELECT;
    end
  end

  // ===========================================================
  // State register; the power-down strobe leaves config untouched
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cur.sclk_d <= 1'b0;
      cur.sel_low_d <= 1'b1;
      cur.bit_cnt <= 3'h0;
      cur.in_shift <= 8'h00;
      cur.out_shift <= 8'h00;
      cur.header_phase <= 1'b1;
      cur.is_read <= 1'b0;
      cur.is_burst <= 1'b0;
      cur.addr <= 6'h00;
      cur.table_idx <= 3'h0;
      cur.serial_out <= 1'b0;
      cur.pin_two_cfg <= radio_cfg_pkg::RST_PIN_TWO_CFG[6:0];
      cur.pin_one_cfg <= radio_cfg_pkg::RST_PIN_ONE_CFG;
      cur.pin_zero_cfg <= radio_cfg_pkg::RST_PIN_ZERO_CFG;
      cur.threshold_select <= radio_cfg_pkg::RST_TX_THRESHOLD_SELECT;
      cur.power_table <= {radio_cfg_pkg::POWER_TABLE_DEPTH{
                          radio_cfg_pkg::RST_POWER_TABLE}};
      cur.strobes <= 9'h000;
      cur.pin_level <= 3'h0;
      cur.pin_enable <= 3'h0;
      cur.thr_reached <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  // ===========================================================
  // Outputs straight from the state register
  assign serial_data_o = cur.serial_out;
  assign general_output_two_o = cur.pin_level[2];
  assign general_output_two_oe_o = cur.pin_enable[2];
  assign general_output_one_o = cur.pin_level[1];
  assign general_output_one_oe_o = cur.pin_enable[1];
  assign general_output_zero_o = cur.pin_level[0];
  assign general_output_zero_oe_o = cur.pin_enable[0];
  assign output_drive_strength_o =
    cur.pin_one_cfg[radio_cfg_pkg::PIN_DRIVE_BIT];
  assign tx_threshold_reached_o = cur.thr_reached;
  assign chip_reset_strobe_o = cur.strobes[0];
  assign synth_on_strobe_o = cur.strobes[1];
  assign crystal_off_strobe_o = cur.strobes[2];
  assign calibrate_strobe_o = cur.strobes[3];
  assign transmit_strobe_o = cur.strobes[4];
  assign idle_strobe_o = cur.strobes[5];
  assign power_down_strobe_o = cur.strobes[6];
  assign flush_tx_strobe_o = cur.strobes[7];
  assign no_op_strobe_o = cur.strobes[8];

endmodule

// *** radio_cfg_sva.sv ***
// Purpose: Port assertions for the serial configuration block
// Assumes: Serial clock half periods of at least two mclk cycles
// Notes: Bound to every radio_cfg_regs instance below
`timescale 1ns/1ps
module radio_cfg_sva (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic serial_clk_i,
  input wire logic serial_sel_low_i,
  input wire logic serial_data_o,
  input wire logic [7:0] tx_byte_count_i,
  input wire logic [63:0] pin_signals_i,
  input wire logic general_output_two_o,
  input wire logic general_output_one_oe_o,
  input wire logic output_drive_strength_o,
  input wire logic tx_threshold_reached_o,
  input wire logic chip_reset_strobe_o,
  input wire logic transmit_strobe_o,
  input wire logic flush_tx_strobe_o
);
  // ==========================================================
  // Clocking and grouped strobes
  default clocking @(posedge mclk_i); endclocking
  wire logic [2:0] stb = {chip_reset_strobe_o, transmit_strobe_o,
                          flush_tx_strobe_o};
  wire logic [6:0] cnt = tx_byte_count_i[6:0];
  // Serial clock rise seen with the device selected
  sequence s_rise_seen;
    $past(serial_clk_i) && !$past(serial_clk_i, 2) &&
    !$past(serial_sel_low_i);
  endsequence

  // ==========================================================
  // Assertions
  chk_strobe_single: assert property (disable iff (sys_rst_i)
    stb != 3'h0 |=> stb == 3'h0) else $error("strobe too long");
  chk_strobe_onehot: assert property (disable iff (sys_rst_i)
    $onehot0(stb)) else $error("two strobes at once");
  chk_strobe_cause: assert property (disable iff (sys_rst_i)
    stb != 3'h0 |-> s_rise_seen) else $error("strobe without clock");
  chk_miso_hold: assert property (disable iff (sys_rst_i)
    serial_clk_i && $past(serial_clk_i) && $past(serial_clk_i, 2) &&
    !serial_sel_low_i && !$past(serial_sel_low_i, 3)
    |-> $stable(serial_data_o)) else $error("read data moved");
  chk_thr_full: assert property (disable iff (sys_rst_i)
    cnt >= 7'h3D && $past(cnt) >= 7'h3D |-> tx_threshold_reached_o)
    else $error("threshold flag missing");
  chk_thr_empty: assert property (disable iff (sys_rst_i)
    cnt == 7'h00 && $past(cnt) == 7'h00 |-> !tx_threshold_reached_o)
    else $error("threshold flag on empty");
  chk_reset_pins: assert property (
    disable iff (sys_rst_i)
    $fell(sys_rst_i) |-> ##2 (!general_output_one_oe_o &&
    !output_drive_strength_o &&
    general_output_two_o == $past(pin_signals_i[41])))
    else $error("pin defaults wrong");
  chk_reset_quiet: assert property (
    sys_rst_i [*2] |-> stb == 3'h0 && !serial_data_o)
    else $error("outputs active in reset");
endmodule

bind radio_cfg_regs radio_cfg_sva chk_u (
  .mclk_i(mclk_i),
  .sys_rst_i(sys_rst_i),
  .serial_clk_i(serial_clk_i),
  .serial_sel_low_i(serial_sel_low_i),
  .serial_data_o(serial_data_o),
  .tx_byte_count_i(tx_byte_count_i),
  .pin_signals_i(pin_signals_i),
  .general_output_two_o(general_output_two_o),
  .general_output_one_oe_o(general_output_one_oe_o),
  .output_drive_strength_o(output_drive_strength_o),
  .tx_threshold_reached_o(tx_threshold_reached_o),
  .chip_reset_strobe_o(chip_reset_strobe_o),
  .transmit_strobe_o(transmit_strobe_o),
  .flush_tx_strobe_o(flush_tx_strobe_o)
);

// *** host_serial_model.sv ***
// Purpose: Host side serial master, mode 0, MSB first
// Assumes: Pins change only at mclk falling edges
// Notes: half sets the serial half period in mclk cycles
`timescale 1ns/1ps
module host_serial_model (
  input wire logic mclk_i,
  output logic sclk_o,
  output logic sel_low_o,
  output logic mosi_o,
  input wire logic miso_i
);
  // ==========================================================
  // Transfer buffers and idle levels
  logic [7:0] wb [8];
  logic [7:0] rb [8];
  logic [7:0] st;
  int half = 4;
  initial begin
    sclk_o = 1'b0;
    sel_low_o = 1'b1;
    mosi_o = 1'b0;
  end

  // One byte: data set while low, read data taken before the rise
  task automatic xbyte(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      mosi_o = b[i];
      repeat (half) @(negedge mclk_i);
      r[i] = miso_i;
      sclk_o = 1'b1;
      repeat (half) @(negedge mclk_i);
      sclk_o = 1'b0;
    end
  endtask

  // Header then n data bytes in one selected frame
  task automatic txn(input logic [7:0] hdr, input int n);
    sel_low_o = 1'b0;
    repeat (half) @(negedge mclk_i);
    xbyte(hdr, st);
    for (int k = 0; k < n; k++) begin
      xbyte(wb[k], rb[k]);
    end
    repeat (half) @(negedge mclk_i);
    sel_low_o = 1'b1;
    mosi_o = ~mosi_o; // Released line shows no stale value
    repeat (half) @(negedge mclk_i);
  endtask
endmodule

// *** tb_radio_cfg_regs.sv ***
// Purpose: Self-checking bench for the serial configuration block
// Assumes: Host model drives the serial pins at mclk falls
// Notes: Strobe pulses are counted by a monitor process
`timescale 1ns/1ps
module tb_radio_cfg_regs;
  // ==========================================================
  // Stimulus and observed signals
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic sclk, sel_low, mosi, miso;
  logic chip_ready_low = 1'b1;
  logic [4:0] radio_state = 5'h0B;
  logic [7:0] pkt_status = 8'hC4;
  logic [7:0] tx_count = 8'h00;
  logic [63:0] sigs = 64'hC3A5_96F0_5A3C_E187;
  logic [8:0] stb;
  logic g2, g2e, g1, g1e, g0, g0e, drive, thr;
  logic [5:0] sa [9] = '{6'h3D, 6'h3B, 6'h39, 6'h36, 6'h35, 6'h33,
                         6'h32, 6'h31, 6'h30};
  int cnt [9] = '{default: 0};
  int old [9];
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  int th;

  // ==========================================================
  // Instances
  host_serial_model host_u (.mclk_i(mclk_i), .sclk_o(sclk),
    .sel_low_o(sel_low), .mosi_o(mosi), .miso_i(miso));
  radio_cfg_regs dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .serial_clk_i(sclk), .serial_sel_low_i(sel_low),
    .serial_data_i(mosi), .serial_data_o(miso),
    .chip_ready_low_i(chip_ready_low), .radio_state_i(radio_state),
    .packet_status_i(pkt_status), .tx_byte_count_i(tx_count),
    .pin_signals_i(sigs), .general_output_two_o(g2),
    .general_output_two_oe_o(g2e), .general_output_one_o(g1),
    .general_output_one_oe_o(g1e), .general_output_zero_o(g0),
    .general_output_zero_oe_o(g0e), .output_drive_strength_o(drive),
    .tx_threshold_reached_o(thr), .chip_reset_strobe_o(stb[8]),
    .synth_on_strobe_o(stb[7]), .crystal_off_strobe_o(stb[6]),
    .calibrate_strobe_o(stb[5]), .transmit_strobe_o(stb[4]),
    .idle_strobe_o(stb[3]), .power_down_strobe_o(stb[2]),
    .flush_tx_strobe_o(stb[1]), .no_op_strobe_o(stb[0]));

  // Clock, strobe counting mid-cycle where pulses stand, and hang guard
  always #2 mclk_i = ~mclk_i;
  always @(negedge mclk_i) begin
    for (int k = 0; k < 9; k++) begin
      if (stb[k] === 1'b1) cnt[k]++;
    end
    cycles++;
    if (cycles == 40000) begin
      failures++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // Tasks
  task automatic chk(input string w, input logic [7:0] e,
                     input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    host_u.wb[0] = d;
    host_u.txn({2'b00, a}, 1);
  endtask
  task automatic rd(input logic [7:0] h, input logic [7:0] e);
    host_u.txn(h, 1);
    chk("read", e, host_u.rb[0]);
  endtask
  task automatic chk4(input logic [31:0] e);
    host_u.txn(8'hC0, 4);
    for (int k = 0; k < 4; k++) chk("cfg", e[8*(3-k) +: 8], host_u.rb[k]);
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (8) @(negedge mclk_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge mclk_i);
    chk("pin2", 8'(sigs[41]), 8'(g2));
    chk("pin1oe", 8'h00, {6'h00, g1e, drive});
    chk("pin0", 8'h07, {5'h00, g2e, g0e, g0 ^ ~sigs[63]});
    chk4(32'h292E3F07);
    chk("status", 8'hB0, host_u.st);
    host_u.wb[0] = 8'h8A;
    host_u.wb[1] = 8'hC5;
    host_u.wb[2] = 8'h07; // Divided clock off at start
    host_u.wb[3] = 8'hF2;
    host_u.txn(8'h40, 4);
    chk4(32'h0AC507F2);
    chk("pins", 8'h0F, {4'h0, g2 ^ ~sigs[10], g1 ^ sigs[5], g1e,
        drive});
    wr(6'h00, 8'h4A);
    rd(8'h80, 8'h4A);
    chk("pin2inv", {7'h00, ~sigs[10]}, 8'(g2));
    for (int a = 'h31; a <= 'h3D; a++) begin
      old = cnt;
      host_u.txn(8'(a), 0);
      for (int j = 0; j < 9; j++) begin
        chk("strobe", 8'(sa[j] == 6'(a)),
            8'(cnt[j] - old[j]));
      end
    end
    chk4(32'h4AC507F2);
    host_u.txn(8'h30, 0);
    chk("reset", 8'h01, 8'(cnt[8] - old[8]));
    chk4(32'h292E3F07);
    rd(8'hF0, 8'h5A);
    rd(8'hF5, {3'h0, radio_state});
    rd(8'hF8, pkt_status);
    tx_count = 8'h2B;
    rd(8'hFA, tx_count);
    host_u.half = 2;
    for (int k = 0; k < 3; k++) host_u.wb[k] = 8'(8'h11 * (k + 1));
    host_u.txn(8'h7E, 3);
    host_u.txn(8'hFE, 3);
    for (int k = 0; k < 3; k++) begin
      chk("table", 8'(8'h11 * (k + 1)), host_u.rb[k]);
    end
    host_u.half = 4;
    rd(8'hBE, 8'h11);
    for (int n = 0; n < 16; n++) begin
      wr(6'h03, 8'(n));
      th = 61 - 4 * n;
      tx_count = 8'(th);
      repeat (3) @(negedge mclk_i);
      chk("thr_at", 8'h01, 8'(thr));
      tx_count = 8'h80 | 8'(th - 1);
      repeat (3) @(negedge mclk_i);
      chk("thr_below", 8'h00, 8'(thr));
    end
    tx_count = 8'h00;
    tally_and_finish();
  end
endmodule
